// ===== rtl/tmf_pkg.sv
// constants for the timer interrupt mask and flag block
package tmf_pkg;

  // ==========================================================
  // addresses
  localparam logic [5:0]  TMF_IO_FLAGS    = 6'h36;  // flag register, I/O space
  localparam logic [5:0]  TMF_IO_MASK     = 6'h37;  // mask register, I/O space
  localparam logic [15:0] TMF_DS_OFFSET   = 16'h0020; // I/O to data space offset
  localparam logic [15:0] TMF_DS_FLAGS    = TMF_DS_OFFSET + {10'h000, TMF_IO_FLAGS};
  localparam logic [15:0] TMF_DS_MASK     = TMF_DS_OFFSET + {10'h000, TMF_IO_MASK};
  localparam logic [15:0] TMF_EXT_BASE    = 16'h0060; // start of extended region
  localparam logic [15:0] TMF_DS_EXT_MASK = 16'h007D; // extended mask register

  // ==========================================================
  // reset values
  localparam logic [7:0]  TMF_FLAGS_RST   = 8'h00;
  localparam logic [7:0]  TMF_MASK_RST    = 8'h00;
  localparam logic [7:0]  TMF_EXT_RST     = 8'h00;

  // ==========================================================
  // bit positions in the shared and extended registers
  localparam int          TMF_CAP_BIT     = 5;
  localparam int          TMF_CMPA_BIT    = 4;
  localparam int          TMF_CMPB_BIT    = 3;
  localparam int          TMF_OVF_BIT     = 2;
  localparam int          TMF_B_CMPC_BIT  = 1;
  localparam int          TMF_A_CMPC_BIT  = 0;
  localparam logic [7:0]  TMF_OWN_SHARED  = 8'h3C; // bits this block answers
  localparam logic [7:0]  TMF_OWN_EXT     = 8'hFF; // whole extended byte
  localparam logic [7:0]  TMF_EXT_USED    = 8'h3F; // implemented extended bits

  // ==========================================================
  // vector indices on the request and acknowledge buses
  localparam int          TMF_NUM_VEC     = 10;
  localparam int          TMF_V_A_CAP     = 0;
  localparam int          TMF_V_A_CMPA    = 1;
  localparam int          TMF_V_A_CMPB    = 2;
  localparam int          TMF_V_A_OVF     = 3;
  localparam int          TMF_V_A_CMPC    = 4;
  localparam int          TMF_V_B_CAP     = 5;
  localparam int          TMF_V_B_CMPA    = 6;
  localparam int          TMF_V_B_CMPB    = 7;
  localparam int          TMF_V_B_OVF     = 8;
  localparam int          TMF_V_B_CMPC    = 9;

endpackage

// ===== rtl/tmf_top.sv
// interrupt mask and flag logic for two 16-bit timers
//
// Summary of operation
// (R01) mask bit 5 with global enable requests first timer capture vector on flag
// (R02) mask bit 4 with global enable requests first timer compare-A vector on flag
// (R03) mask bit 3 with global enable requests first timer compare-B vector on flag
// (R04) mask bit 2 with global enable requests first timer overflow vector on flag
// (R05) extended bit 5 with global enable requests second timer capture vector
// (R06) extended bit 4 with global enable requests second timer compare-A vector
// (R07) extended bit 3 with global enable requests second timer compare-B vector
// (R08) extended bit 2 with global enable requests second timer overflow vector
// (R09) extended bit 1 with global enable requests second timer compare-C vector
// (R10) extended bit 0 with global enable requests first timer compare-C vector
// (R11) flag register holds capture, compare-A, compare-B, overflow at bits 5..2
// (R12) mask register at I/O 0x37, data 0x57, resets to zero
// (R13) flag register at I/O 0x36, data 0x56
// (R14) extended mask at 0x7D, resets zero, absent in legacy configuration
// (R15) I/O instructions reach only addresses 0x00 to 0x3F
// (R16) data-space address of an I/O register is its offset plus 0x20
// (R17) extended region from 0x60 reachable by load and store only
// (R18) bits 7, 6, 1, 0 of shared registers belong to other timers
// (R19) flags clear when their vector runs or on a written one
// (R20) compare flag sets one timer cycle after counter equals compare value
// (R21) forced compare strobe never sets a compare flag
// (R22) capture flag sets on capture, or at top when capture is top
// (R23) writing zero leaves a flag alone; flags stay set until cleared
// (R24) request is flag AND mask AND global enable; masked flags stay pending
`timescale 1ns/10ps

module tmf_top
  import tmf_pkg::*;
(
  input  wire logic                   ref_clk,
  input  wire logic                   rst,
  // core status and configuration
  input  wire logic                   gie,
  input  wire logic                   compat_mode,
  // I/O instruction port
  input  wire logic [5:0]             io_addr,
  input  wire logic                   io_wr,
  input  wire logic                   io_rd,
  input  wire logic [7:0]             io_wdata,
  // data-space load and store port
  input  wire logic [15:0]            ds_addr,
  input  wire logic                   ds_wr,
  input  wire logic                   ds_rd,
  input  wire logic [7:0]             ds_wdata,
  // first timer events
  input  wire logic                   timer_tick,
  input  wire logic                   t_a_capture_event,
  input  wire logic                   t_a_cap_is_top,
  input  wire logic                   t_a_at_top,
  input  wire logic                   t_a_cmp_a_eq,
  input  wire logic                   t_a_cmp_b_eq,
  input  wire logic                   t_a_ovf_event,
  input  wire logic                   forced_compare_strobe,
  input  wire logic                   forced_compare_b_strobe,
  // flags held by the extended flag register
  input  wire logic [5:0]             extended_timer_event_flags,
  // vector execution acknowledge, one-hot
  input  wire logic [TMF_NUM_VEC-1:0] vec_ack,
  // read answer
  output logic [7:0]                  rd_data,
  output logic                        rd_valid,
  output logic [7:0]                  rd_own_bits,
  // interrupt requests and extended flag clears
  output logic [TMF_NUM_VEC-1:0]      irq_req,
  output logic [5:0]                  ext_flag_clear
);

  // ==========================================================
  // storage
  logic [7:0]             timer_event_flags_r;
  logic [7:0]             timer_event_flags_nxt;
  logic [7:0]             timer_irq_mask_r;
  logic [7:0]             extended_timer_irq_mask_r;
  logic                   cmp_a_pend_r;
  logic                   cmp_a_pend_nxt;
  logic                   cmp_b_pend_r;
  logic                   cmp_b_pend_nxt;
  logic [7:0]             rd_data_r;
  logic                   rd_valid_r;
  logic [7:0]             rd_own_r;
  logic [TMF_NUM_VEC-1:0] irq_req_r;
  logic [TMF_NUM_VEC-1:0] irq_req_nxt;
  logic [5:0]             ext_flag_clear_r;

  // decode results
  logic                   wr_flags;
  logic                   wr_mask;
  logic                   wr_ext;
  logic                   rd_flags;
  logic                   rd_mask;
  logic                   rd_ext;
  logic [7:0]             wdata;

  // flag set and clear terms
  logic [7:0]             flag_set;
  logic [7:0]             flag_clr;

  // ==========================================================
  // address decode
  // the I/O port is six bits wide, so it only ever reaches 0x00..0x3F
  // and can never touch the extended region; an I/O access wins if
  // the core presents both ports in one cycle
  always_comb begin
    wr_flags = 1'b0;
    wr_mask  = 1'b0;
    wr_ext   = 1'b0;
    rd_flags = 1'b0;
    rd_mask  = 1'b0;
    rd_ext   = 1'b0;
    wdata    = io_wdata;
    if (io_wr || io_rd) begin
      wr_flags = io_wr && (io_addr == TMF_IO_FLAGS);  // R13 R15
      wr_mask  = io_wr && (io_addr == TMF_IO_MASK);   // R12 R15
      rd_flags = io_rd && (io_addr == TMF_IO_FLAGS);  // R13 R15
      rd_mask  = io_rd && (io_addr == TMF_IO_MASK);   // R12 R15
    end else begin
      wdata    = ds_wdata;
      wr_flags = ds_wr && (ds_addr == TMF_DS_FLAGS);  // R13 R16
      wr_mask  = ds_wr && (ds_addr == TMF_DS_MASK);   // R12 R16
      rd_flags = ds_rd && (ds_addr == TMF_DS_FLAGS);  // R13 R16
      rd_mask  = ds_rd && (ds_addr == TMF_DS_MASK);   // R12 R16
      // extended mask exists only outside the legacy configuration
      wr_ext   = ds_wr && (ds_addr == TMF_DS_EXT_MASK) && !compat_mode; // R14 R17
      rd_ext   = ds_rd && (ds_addr == TMF_DS_EXT_MASK) && !compat_mode; // R14 R17
    end
  end

  // ==========================================================
  // mask register, only the first timer's bits are stored here
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      timer_irq_mask_r <= TMF_MASK_RST;  // R12
    end else if (wr_mask) begin
      // bits 7, 6, 1, 0 stay zero here; other timers hold them
      timer_irq_mask_r <= wdata & TMF_OWN_SHARED;  // R18
    end
  end

  // ==========================================================
  // extended mask register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      extended_timer_irq_mask_r <= TMF_EXT_RST;  // R14
    end else if (wr_ext) begin
      extended_timer_irq_mask_r <= wdata & TMF_EXT_USED;  // R14
    end
  end

  // ==========================================================
  // compare match pending stage
  // a match seen on one timer tick becomes a flag on the next tick;
  // a forced compare makes the compare unit see an equal value, so
  // that tick must not arm the flag
  always_comb begin
    cmp_a_pend_nxt = cmp_a_pend_r;
    if (timer_tick) begin
      cmp_a_pend_nxt = t_a_cmp_a_eq && !forced_compare_strobe;    // R20 R21
    end
  end

  // compare B arm, same timing as compare A
  always_comb begin
    cmp_b_pend_nxt = cmp_b_pend_r;
    if (timer_tick) begin
      cmp_b_pend_nxt = t_a_cmp_b_eq && !forced_compare_b_strobe;  // R20 R21
    end
  end

  // compare A pending register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cmp_a_pend_r <= 1'b0;
    end else begin
      cmp_a_pend_r <= cmp_a_pend_nxt;  // R20
    end
  end

  // compare B pending register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cmp_b_pend_r <= 1'b0;
    end else begin
      cmp_b_pend_r <= cmp_b_pend_nxt;  // R20
    end
  end

  // ==========================================================
  // flag set terms from the first timer
  always_comb begin
    flag_set = 8'h00;
    // capture pin event, or reaching top while capture register is top
    flag_set[TMF_CAP_BIT]  = t_a_capture_event ||
                             (t_a_cap_is_top && t_a_at_top);      // R22
    flag_set[TMF_CMPA_BIT] = timer_tick && cmp_a_pend_r;          // R20
    flag_set[TMF_CMPB_BIT] = timer_tick && cmp_b_pend_r;          // R20
    flag_set[TMF_OVF_BIT]  = t_a_ovf_event;
  end

  // ==========================================================
  // flag clear terms: a written one or the vector being executed
  always_comb begin
    flag_clr = 8'h00;
    if (wr_flags) begin
      flag_clr = wdata & TMF_OWN_SHARED;  // R19 R23
    end
    flag_clr[TMF_CAP_BIT]  = flag_clr[TMF_CAP_BIT]  || vec_ack[TMF_V_A_CAP];   // R19
    flag_clr[TMF_CMPA_BIT] = flag_clr[TMF_CMPA_BIT] || vec_ack[TMF_V_A_CMPA];  // R19
    flag_clr[TMF_CMPB_BIT] = flag_clr[TMF_CMPB_BIT] || vec_ack[TMF_V_A_CMPB];  // R19
    flag_clr[TMF_OVF_BIT]  = flag_clr[TMF_OVF_BIT]  || vec_ack[TMF_V_A_OVF];   // R19
  end

  // ==========================================================
  // flag next value: a set arriving with a clear wins, so no event
  // is lost; flags are held until cleared
  always_comb begin
    timer_event_flags_nxt = (flag_set | (timer_event_flags_r & ~flag_clr)) &
                            TMF_OWN_SHARED;  // R11 R18 R23
  end

  // flag register
  // bits owned by other timers are masked to zero and never stored
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      timer_event_flags_r <= TMF_FLAGS_RST;  // R11
    end else begin
      timer_event_flags_r <= timer_event_flags_nxt;  // R11 R23
    end
  end

  // ==========================================================
  // interrupt requests: flag AND mask AND global enable
  // a masked flag keeps its state and raises its request once the
  // mask or global enable is set
  always_comb begin
    irq_req_nxt = '0;
    irq_req_nxt[TMF_V_A_CAP]  = gie && timer_irq_mask_r[TMF_CAP_BIT] &&
                                timer_event_flags_r[TMF_CAP_BIT];        // R01 R24
    irq_req_nxt[TMF_V_A_CMPA] = gie && timer_irq_mask_r[TMF_CMPA_BIT] &&
                                timer_event_flags_r[TMF_CMPA_BIT];       // R02 R24
    irq_req_nxt[TMF_V_A_CMPB] = gie && timer_irq_mask_r[TMF_CMPB_BIT] &&
                                timer_event_flags_r[TMF_CMPB_BIT];       // R03 R24
    irq_req_nxt[TMF_V_A_OVF]  = gie && timer_irq_mask_r[TMF_OVF_BIT] &&
                                timer_event_flags_r[TMF_OVF_BIT];        // R04 R24
    if (!compat_mode) begin
      irq_req_nxt[TMF_V_B_CAP]  = gie && extended_timer_irq_mask_r[TMF_CAP_BIT] &&
                                  extended_timer_event_flags[TMF_CAP_BIT];     // R05 R24
      irq_req_nxt[TMF_V_B_CMPA] = gie && extended_timer_irq_mask_r[TMF_CMPA_BIT] &&
                                  extended_timer_event_flags[TMF_CMPA_BIT];    // R06 R24
      irq_req_nxt[TMF_V_B_CMPB] = gie && extended_timer_irq_mask_r[TMF_CMPB_BIT] &&
                                  extended_timer_event_flags[TMF_CMPB_BIT];    // R07 R24
      irq_req_nxt[TMF_V_B_OVF]  = gie && extended_timer_irq_mask_r[TMF_OVF_BIT] &&
                                  extended_timer_event_flags[TMF_OVF_BIT];     // R08 R24
      irq_req_nxt[TMF_V_B_CMPC] = gie && extended_timer_irq_mask_r[TMF_B_CMPC_BIT] &&
                                  extended_timer_event_flags[TMF_B_CMPC_BIT];  // R09 R24
      irq_req_nxt[TMF_V_A_CMPC] = gie && extended_timer_irq_mask_r[TMF_A_CMPC_BIT] &&
                                  extended_timer_event_flags[TMF_A_CMPC_BIT];  // R10 R24
    end
  end

  // request register
  // registered so each request comes straight from a flip-flop
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      irq_req_r <= '0;
    end else begin
      irq_req_r <= irq_req_nxt;  // R24
    end
  end

  // ==========================================================
  // clears for flags that live in the extended flag register
  // the holder of those flags clears the bit two cycles after the ack
  // one pulse per acknowledge, treated there like a written one
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ext_flag_clear_r <= 6'h00;
    end else begin
      ext_flag_clear_r[TMF_CAP_BIT]    <= vec_ack[TMF_V_B_CAP];   // R19
      ext_flag_clear_r[TMF_CMPA_BIT]   <= vec_ack[TMF_V_B_CMPA];  // R19
      ext_flag_clear_r[TMF_CMPB_BIT]   <= vec_ack[TMF_V_B_CMPB];  // R19
      ext_flag_clear_r[TMF_OVF_BIT]    <= vec_ack[TMF_V_B_OVF];   // R19
      ext_flag_clear_r[TMF_B_CMPC_BIT] <= vec_ack[TMF_V_B_CMPC];  // R19
      ext_flag_clear_r[TMF_A_CMPC_BIT] <= vec_ack[TMF_V_A_CMPC];  // R19
    end
  end

  // ==========================================================
  // read answer, one cycle after the read strobe
  // values are those before any same-cycle write; rd_own_bits tells
  // the core which bits this block drives so it can merge the bytes
  // answered by the other timers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rd_valid_r <= 1'b0;
    end else begin
      rd_valid_r <= rd_flags || rd_mask || rd_ext;
    end
  end

  // read data, zero when nothing is read
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rd_data_r <= 8'h00;
    end else if (rd_flags) begin
      rd_data_r <= timer_event_flags_r;  // R11 R13
    end else if (rd_mask) begin
      rd_data_r <= timer_irq_mask_r;     // R12
    end else if (rd_ext) begin
      rd_data_r <= extended_timer_irq_mask_r;  // R14
    end else begin
      rd_data_r <= 8'h00;
    end
  end

  // ownership of the answered bits
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rd_own_r <= 8'h00;
    end else if (rd_flags) begin
      rd_own_r <= TMF_OWN_SHARED;  // R18
    end else if (rd_mask) begin
      rd_own_r <= TMF_OWN_SHARED;  // R18
    end else if (rd_ext) begin
      rd_own_r <= TMF_OWN_EXT;
    end else begin
      rd_own_r <= 8'h00;
    end
  end

  // ==========================================================
  // outputs
  // every output is a register; no logic sits between the flip-flops
  // and the ports, so the core sees no glitches
  assign rd_data        = rd_data_r;
  assign rd_valid       = rd_valid_r;
  assign rd_own_bits    = rd_own_r;
  assign irq_req        = irq_req_r;
  assign ext_flag_clear = ext_flag_clear_r;

endmodule // tmf_top

// ===== sim/tmf_core_model.sv
// core and second-timer model: vector service and extended flag register
`timescale 1ns/10ps
module tmf_core_model
  import tmf_pkg::*;
(
  input  wire logic                   ref_clk,
  input  wire logic                   rst,
  input  wire logic                   ack_en,
  input  wire logic [5:0]             ext_set,
  input  wire logic [5:0]             ext_flag_clear,
  input  wire logic [TMF_NUM_VEC-1:0] irq_req,
  output logic [TMF_NUM_VEC-1:0]      vec_ack,
  output logic [5:0]                  ext_flags
);
  logic [1:0] hold_r;
  // ==========================================================
  // extended flags: timer sets win over device clears
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) ext_flags <= 6'h00;
    else ext_flags <= (ext_flags & ~ext_flag_clear) | ext_set;
  end
  // execute the lowest pending vector, then wait out the request lag
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      vec_ack <= 10'h000;
      hold_r <= 2'h0;
    end else if (hold_r != 2'h0) begin
      vec_ack <= 10'h000;
      hold_r <= hold_r - 2'h1;
    end else if (ack_en && irq_req != 10'h000) begin
      vec_ack <= irq_req & (~irq_req + 10'h001);
      hold_r <= 2'h3;
    end
  end
endmodule // tmf_core_model

// ===== sim/tmf_chk_sva.sv
// port assertions for the timer interrupt mask and flag block
`timescale 1ns/10ps
module tmf_chk
  import tmf_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        gie,
  input wire logic        compat_mode,
  input wire logic [5:0]  io_addr,
  input wire logic        io_wr,
  input wire logic        io_rd,
  input wire logic [15:0] ds_addr,
  input wire logic        ds_rd,
  input wire logic        t_a_ovf_event,
  input wire logic [5:0]  extended_timer_event_flags,
  input wire logic [9:0]  vec_ack,
  input wire logic [7:0]  rd_data,
  input wire logic        rd_valid,
  input wire logic [7:0]  rd_own_bits,
  input wire logic [9:0]  irq_req,
  input wire logic [5:0]  ext_flag_clear
);
  logic       ds_sel, sh_rd, ex_rd;
  logic [5:0] ack_map;
  // ==========================================================
  // read decode as the core sees it; io strobes mask the ds port
  assign ds_sel = ds_rd && !io_rd && !io_wr;
  assign sh_rd = (io_rd && (io_addr == TMF_IO_FLAGS || io_addr == TMF_IO_MASK))
    || (ds_sel && (ds_addr == TMF_DS_FLAGS || ds_addr == TMF_DS_MASK));
  assign ex_rd = ds_sel && ds_addr == TMF_DS_EXT_MASK && !compat_mode;
  assign ack_map = {vec_ack[5], vec_ack[6], vec_ack[7], vec_ack[8], vec_ack[9], vec_ack[4]};
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence s_sh_rd; sh_rd; endsequence
  sequence s_ex_rd; ex_rd; endsequence
  sequence s_ovf_ack; vec_ack[TMF_V_A_OVF] && !t_a_ovf_event ##1 1'b1; endsequence
  property p_rd_valid; rd_valid == $past(sh_rd || ex_rd); endproperty
  a_rd_valid: assert property (p_rd_valid)
    else $error("read answer does not match the decoded read");
  property p_rd_shared;
    s_sh_rd |=> rd_own_bits == TMF_OWN_SHARED && (rd_data & 8'hC3) == 8'h00;
  endproperty
  a_rd_shared: assert property (p_rd_shared)
    else $error("shared read shows bits of other timers");
  property p_rd_ext; s_ex_rd |=> rd_own_bits == TMF_OWN_EXT && rd_data[7:6] == 2'h0; endproperty
  a_rd_ext: assert property (p_rd_ext)
    else $error("extended mask read has wrong ownership or top bits");
  property p_gie_off; !gie |=> irq_req == 10'h000; endproperty
  a_gie_off: assert property (p_gie_off)
    else $error("request raised with global enable low");
  property p_ext_off;
    (compat_mode || extended_timer_event_flags == 6'h00) |=> irq_req[9:4] == 6'h00;
  endproperty
  a_ext_off: assert property (p_ext_off)
    else $error("extended request without flag or in legacy mode");
  property p_ovf_ack; s_ovf_ack |=> !irq_req[TMF_V_A_OVF]; endproperty
  a_ovf_ack: assert property (p_ovf_ack)
    else $error("overflow request survives its vector");
  property p_ext_clr; ext_flag_clear == $past(ack_map); endproperty
  a_ext_clr: assert property (p_ext_clr)
    else $error("extended flag clear does not follow vector acknowledge");
  property p_rst_rel; $fell(rst) |-> irq_req == 10'h000 && !rd_valid; endproperty
  a_rst_rel: assert property (p_rst_rel)
    else $error("outputs active at the first edge after reset");
endmodule // tmf_chk
bind tmf_top tmf_chk tmf_chk_inst (.*);

// ===== sim/timer_interrupt_mask_flags_tb.sv
// self-checking bench for the timer interrupt mask and flag block
`timescale 1ns/10ps
module timer_interrupt_mask_flags_tb
  import tmf_pkg::*;
;
  logic ref_clk, rst, gie, compat_mode, io_wr, io_rd, ds_wr, ds_rd, ack_en, timer_tick;
  logic t_a_capture_event, t_a_cap_is_top, t_a_at_top, t_a_cmp_a_eq, t_a_cmp_b_eq;
  logic t_a_ovf_event, forced_compare_strobe, forced_compare_b_strobe, rd_valid;
  logic [5:0]  io_addr, ext_set, extended_timer_event_flags, ext_flag_clear, em, efl;
  logic [15:0] ds_addr, lfsr_r;
  logic [7:0]  io_wdata, ds_wdata, rd_data, rd_own_bits, fl, m;
  logic [9:0]  vec_ack, irq_req;
  int          n_mismatch, compares, t;
  tmf_top tmf_top_inst (.*);
  tmf_core_model tmf_core_model_inst (.ref_clk(ref_clk), .rst(rst), .ack_en(ack_en),
    .ext_set(ext_set), .ext_flag_clear(ext_flag_clear), .irq_req(irq_req),
    .vec_ack(vec_ack), .ext_flags(extended_timer_event_flags));
  // ==========================================================
  // clock and helpers
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  function automatic logic [15:0] lfsr(logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // expected requests from flags, masks, global enable and legacy mode
  function automatic logic [9:0] exp_irq(logic [7:0] f, logic [7:0] k, logic [5:0] x,
                                         logic [5:0] y, logic g, logic c);
    logic [7:0] a;
    logic [5:0] b;
    a = f & k;
    b = x & y & {6{~c}};
    return g ? {b[1], b[2], b[3], b[4], b[5], b[0], a[2], a[3], a[4], a[5]} : 10'h000;
  endfunction
  task automatic acc(bit io, bit w, logic [15:0] a, logic [7:0] d);
    @(posedge ref_clk);
    if (io) {io_wr, io_rd, io_addr, io_wdata} <= {w, !w, a[5:0], d};
    else {ds_wr, ds_rd, ds_addr, ds_wdata} <= {w, !w, a, d};
    @(posedge ref_clk);
    {io_wr, io_rd, ds_wr, ds_rd} <= 4'h0;
  endtask
  task automatic rd(bit io, logic [15:0] a, logic [7:0] exp, logic v);
    acc(io, 1'b0, a, 8'h00);
    #1;
    chk("rd_valid", 16'(rd_valid), 16'(v));
    if (v) chk("rd_data", 16'(rd_data), 16'(exp));
  endtask
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // ==========================================================
  // main sequence
  initial begin
    {gie, compat_mode, io_wr, io_rd, ds_wr, ds_rd, ack_en, timer_tick} = 8'h00;
    {t_a_capture_event, t_a_cap_is_top, t_a_at_top, t_a_cmp_a_eq, t_a_cmp_b_eq} = 5'h00;
    {t_a_ovf_event, forced_compare_strobe, forced_compare_b_strobe} = 3'h0;
    {io_addr, ds_addr, io_wdata, ds_wdata, ext_set} = 44'h0;
    lfsr_r = 16'h000D;
    rst = 1'b1;
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    rd(1, 16'(TMF_IO_FLAGS), 8'h00, 1);
    rd(1, 16'(TMF_IO_MASK), 8'h00, 1);
    rd(0, TMF_DS_EXT_MASK, 8'h00, 1);
    acc(0, 1, TMF_DS_MASK, 8'hFF);
    rd(1, 16'(TMF_IO_MASK), 8'h3C, 1);
    acc(0, 1, TMF_DS_EXT_MASK, 8'hFF);
    rd(0, TMF_DS_EXT_MASK, 8'h3F, 1);
    @(posedge ref_clk);
    compat_mode <= 1'b1;
    rd(0, TMF_DS_EXT_MASK, 8'h00, 0);
    rd(0, 16'h0036, 8'h00, 0);
    rd(0, TMF_EXT_BASE, 8'h00, 0);
    rd(1, 16'h003D, 8'h00, 0);
    rd(0, TMF_DS_FLAGS, 8'h00, 1);
    $display("test registers done");
    // compare arms on one tick and sets on the next; forced strobes never arm
    for (int k = 0; k < 2; k++) begin
      @(posedge ref_clk);
      {timer_tick, t_a_cmp_a_eq, t_a_cmp_b_eq} <= 3'h7;
      {forced_compare_strobe, forced_compare_b_strobe} <= {2{k == 0}};
      @(posedge ref_clk);
      {timer_tick, t_a_cmp_a_eq, t_a_cmp_b_eq} <= 3'h0;
      {forced_compare_strobe, forced_compare_b_strobe} <= 2'h0;
      rd(1, 16'(TMF_IO_FLAGS), 8'h00, 1);
      @(posedge ref_clk);
      timer_tick <= 1'b1;
      @(posedge ref_clk);
      timer_tick <= 1'b0;
      rd(1, 16'(TMF_IO_FLAGS), k ? 8'h18 : 8'h00, 1);
    end
    $display("test compare done");
    {fl, m, em, efl} = {8'h18, 8'h3C, 6'h3F, 6'h00};
    // random events, masks, enables and write-one clears
    for (int i = 0; i < 24; i++) begin
      lfsr_r = lfsr(lfsr_r);
      @(posedge ref_clk);
      {t_a_ovf_event, t_a_capture_event, t_a_cap_is_top, t_a_at_top} <= lfsr_r[3:0];
      {ext_set, gie, compat_mode} <= lfsr_r[11:4];
      @(posedge ref_clk);
      {t_a_ovf_event, t_a_capture_event, t_a_at_top, ext_set} <= 9'h000;
      fl = fl | {2'h0, lfsr_r[2] | (lfsr_r[1] & lfsr_r[0]), 2'h0, lfsr_r[3], 2'h0};
      efl = efl | lfsr_r[11:6];
      acc(lfsr_r[12], 1, lfsr_r[12] ? 16'(TMF_IO_MASK) : TMF_DS_MASK, lfsr_r[15:8]);
      m = lfsr_r[15:8] & 8'h3C;
      acc(0, 1, TMF_DS_EXT_MASK, lfsr_r[13:6]);
      if (!compat_mode) em = lfsr_r[11:6];
      rd(1, 16'(TMF_IO_FLAGS), fl, 1);
      chk("irq_req", 16'(irq_req), 16'(exp_irq(fl, m, efl, em, gie, compat_mode)));
      acc(1, 1, 16'(TMF_IO_FLAGS), lfsr_r[7:0]);
      fl = fl & ~(lfsr_r[7:0] & 8'h3C);
      rd(0, TMF_DS_FLAGS, fl, 1);
    end
    $display("test random done");
    // core services every pending vector until nothing is left
    @(posedge ref_clk);
    {gie, compat_mode, ack_en, t_a_ovf_event, ext_set} <= {3'h5, 1'b1, 6'h3F};
    @(posedge ref_clk);
    {t_a_ovf_event, ext_set} <= 7'h00;
    acc(1, 1, 16'(TMF_IO_MASK), 8'hFF);
    acc(0, 1, TMF_DS_EXT_MASK, 8'hFF);
    @(posedge ref_clk);
    #1;
    t = 0;
    while (irq_req !== 10'h000 && t < 200) begin
      @(posedge ref_clk);
      #1;
      t++;
    end
    repeat (4) @(posedge ref_clk);
    rd(1, 16'(TMF_IO_FLAGS), 8'h00, 1);
    chk("irq_req", 16'(irq_req), 16'h0000);
    chk("ext_flags", 16'(extended_timer_event_flags), 16'h0000);
    $display("test drain done");
    tally_and_finish();
  end
  // watchdog: the whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge ref_clk);
    n_mismatch++;
    tally_and_finish();
  end
endmodule // timer_interrupt_mask_flags_tb
